/* File: hdl/pms_pkg.sv */
package pms_pkg;
    // control port serial format chosen from the clock line strap
    typedef enum logic {PMS_SER_SPI, PMS_SER_I2C} pms_ser_fmt_t;
    // parallel handshake timing
    typedef enum logic {PMS_PAR_SYNC, PMS_PAR_HANDSHAKE_TIMING_SELECT} pms_par_timing_t;
    // reset release to strap capture, in cycles
    localparam logic [3:0] PMS_STRAP_SETTLE = 4'h8;
    // receive inactivity time before zero-power, in microseconds
    localparam int PMS_IDLE_US = 1000;
    localparam int PMS_CLK_MHZ = 125;
    localparam int PMS_IDLE_CYCLES = PMS_IDLE_US * PMS_CLK_MHZ;
    // receiver wake-up sampling: period and on-time, in microseconds
    localparam int PMS_WAKE_PERIOD_US = 10000;
    localparam int PMS_WAKE_ON_US = 100;
    localparam int PMS_WAKE_PERIOD_CYCLES = PMS_WAKE_PERIOD_US * PMS_CLK_MHZ;
    localparam int PMS_WAKE_ON_CYCLES = PMS_WAKE_ON_US * PMS_CLK_MHZ;
    localparam int PMS_CNT_W = 24;
endpackage

/* File: hdl/pms_sync_if.sv */
`timescale 1ns/1ps
interface pms_sync_if;
    logic scl_s;
    logic parallel_source_select_s;
    logic parallel_control_select_s;
    logic timing_s;
    logic rd_n_s;
    logic wr_n_s;
    logic rx_s;
    logic fsync_s;
    logic source_flow_flag_s;
    logic control_flow_flag_s;
    modport sync (output scl_s, parallel_source_select_s, parallel_control_select_s, timing_s, rd_n_s, wr_n_s, rx_s,
        fsync_s, source_flow_flag_s, control_flow_flag_s);
    modport core (input scl_s, parallel_source_select_s, parallel_control_select_s, timing_s, rd_n_s, wr_n_s, rx_s,
        fsync_s, source_flow_flag_s, control_flow_flag_s);
endinterface

/* File: hdl/pms_sync.sv */
`timescale 1ns/1ps
module pms_sync (
    input wire logic clock, // core clock
    input wire logic rst_b, // sync reset, active low
    input wire logic [9:0] raw_in, // asynchronous pins
    pms_sync_if.sync s // synchronised copies
);
    typedef struct packed {
        logic [9:0] meta;
        logic [9:0] stable;
    } pms_sync_st_t;
    pms_sync_st_t st_reg;
    pms_sync_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.meta = raw_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign s.scl_s = st_reg.stable[0];
    assign s.parallel_source_select_s = st_reg.stable[1];
    assign s.parallel_control_select_s = st_reg.stable[2];
    assign s.timing_s = st_reg.stable[3];
    assign s.rd_n_s = st_reg.stable[4];
    assign s.wr_n_s = st_reg.stable[5];
    assign s.rx_s = st_reg.stable[6];
    assign s.fsync_s = st_reg.stable[7];
    assign s.source_flow_flag_s = st_reg.stable[8];
    assign s.control_flow_flag_s = st_reg.stable[9];
endmodule

/* File: hdl/pms_top.sv */
`timescale 1ns/1ps
module pms_top #(
    parameter int IDLE_CYCLES = pms_pkg::PMS_IDLE_CYCLES, // silence before zero-power
    parameter int WAKE_PERIOD_CYCLES = pms_pkg::PMS_WAKE_PERIOD_CYCLES, // wake period
    parameter int WAKE_ON_CYCLES = pms_pkg::PMS_WAKE_ON_CYCLES // wake on-time
) (
    input wire logic clock, // core clock, 125 MHz
    input wire logic rst_b, // power-up reset, active low
    input wire logic scl_pin, // serial clock strap
    input wire logic parallel_source_select, // source port mode strap
    input wire logic parallel_control_select, // control port mode strap
    input wire logic handshake_timing_select, // handshake_timing_select handshake strap
    input wire logic rd_n, // read strobe pin
    input wire logic wr_n, // write strobe pin
    input wire logic rx_pin, // network receive line
    input wire logic frame_sync, // frame sync from port logic
    input wire logic source_flow_flag, // source flow from port logic
    input wire logic control_flow_flag, // control flow from port logic
    input wire logic core_ready, // port logic ready for access
    output logic serial_i2c_mode, // 1 i2c, 0 spi
    output logic source_parallel_mode, // source ports parallel
    output logic control_parallel_mode, // control port parallel
    output logic handshake_timing_select_handshake_mode, // asynchronous parallel timing
    output logic standalone_mode, // stand-alone operation
    output logic use_recovered_clock, // clock taken from receive line
    output logic serial_lines_idle_req, // serial port lines unused
    output logic [2:0] parallel_status, // control_flow_flag, source_flow_flag, fsync bits
    output logic frame_sync_out, // dedicated frame sync pin
    output logic source_flow_out, // dedicated source flow pin
    output logic control_flow_out, // dedicated control flow pin
    output logic int_n, // ready/alert output, active low
    output logic power_status, // low requests peripheral power
    output logic zero_power, // block in zero-power state
    output logic wake_up // receiver power enable
);
    typedef enum logic [1:0] {PMS_SETTLE, PMS_RUN} pms_phase_t;
    typedef struct packed {
        pms_phase_t phase;
        logic [3:0] settle;
        logic i2c;
        logic src_par;
        logic cp_par;
        logic handshake_timing_select_t;
        logic alone;
        logic ready;
        logic rx_last;
        logic zp;
        logic [pms_pkg::PMS_CNT_W-1:0] idle_cnt;
        logic [pms_pkg::PMS_CNT_W-1:0] wake_cnt;
        logic [2:0] flags;
        // output copies registered so the pins never glitch
        logic pwr;
        logic alert_n;
        logic wake;
    } pms_top_st_t;

    localparam logic [pms_pkg::PMS_CNT_W-1:0] IDLE_LAST = pms_pkg::PMS_CNT_W'(IDLE_CYCLES - 1);
    localparam logic [pms_pkg::PMS_CNT_W-1:0] WAKE_LAST =
        pms_pkg::PMS_CNT_W'(WAKE_PERIOD_CYCLES - 1);
    localparam logic [pms_pkg::PMS_CNT_W-1:0] WAKE_ON = pms_pkg::PMS_CNT_W'(WAKE_ON_CYCLES);

    pms_sync_if sif();
    pms_top_st_t st_reg;
    pms_top_st_t st_next;
    logic rx_edge;
    logic capture_now;
    logic idle_done;
    logic wake_wrap;

    pms_sync u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .raw_in({
            control_flow_flag,
            source_flow_flag,
            frame_sync,
            rx_pin,
            wr_n,
            rd_n,
            handshake_timing_select,
            parallel_control_select,
            parallel_source_select,
            scl_pin
        }),
        .s(sif.sync)
    );

    // any change of level on the receive line counts as activity
    assign rx_edge = sif.rx_s ^ st_reg.rx_last;
    assign capture_now = (st_reg.settle == pms_pkg::PMS_STRAP_SETTLE);
    // idle counter saturates so a long silence cannot wrap into a wake
    assign idle_done = (st_reg.idle_cnt == IDLE_LAST);
    assign wake_wrap = (st_reg.wake_cnt == WAKE_LAST);

    always_comb
    begin
        st_next = st_reg;
        st_next.rx_last = sif.rx_s;

        unique case (st_reg.phase)
            PMS_SETTLE:
            begin
                // straps get time to pass the synchroniser before capture
                if (capture_now)
                begin
                    st_next.phase = PMS_RUN;
                    st_next.i2c = sif.scl_s;
                    st_next.src_par = sif.parallel_source_select_s;
                    // parallel control without parallel source is refused
                    st_next.cp_par = sif.parallel_control_select_s & sif.parallel_source_select_s;
                    st_next.handshake_timing_select_t = sif.timing_s;
                    // stand-alone needs both strobes low at the capture edge
                    st_next.alone = ~sif.rd_n_s & ~sif.wr_n_s;
                end
                else
                begin
                    st_next.settle = st_reg.settle + 4'h1;
                end
            end

            PMS_RUN:
            begin
                // ready is sticky; straps are never looked at again here
                st_next.ready = st_reg.ready | core_ready;
                if (st_reg.src_par)
                begin
                    // cp bit masked so a refused control mode never reports flow
                    st_next.flags = {sif.control_flow_flag_s & st_reg.cp_par, sif.source_flow_flag_s,
                        sif.fsync_s};
                end
                if (st_reg.alone)
                begin
                    if (rx_edge)
                    begin
                        st_next.zp = 1'b0;
                        st_next.idle_cnt = '0;
                    end
                    else if (idle_done)
                    begin
                        st_next.zp = 1'b1;
                    end
                    else
                    begin
                        st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
                    end
                    // free-running sample period; its phase against rx does not matter
                    if (wake_wrap)
                    begin
                        st_next.wake_cnt = '0;
                    end
                    else
                    begin
                        st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
                    end
                end
            end

            default:
            begin
                // unused phase code: restart the capture
                st_next.phase = PMS_SETTLE;
            end
        endcase

        // output copies built from next state keep the same timing as the state
        st_next.pwr = st_next.alone & st_next.zp;
        st_next.alert_n = ~st_next.ready;
        st_next.wake = ~st_next.alone | ~st_next.zp | (st_next.wake_cnt < WAKE_ON);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
            st_reg.phase <= PMS_SETTLE;
            // zero-power from the start: no activity seen yet
            st_reg.zp <= 1'b1;
            st_reg.alert_n <= 1'b1;
            st_reg.wake <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // captured modes drive the pins straight from flops
    assign serial_i2c_mode = st_reg.i2c;
    assign source_parallel_mode = st_reg.src_par;
    assign control_parallel_mode = st_reg.cp_par;
    assign handshake_timing_select_handshake_mode = st_reg.handshake_timing_select_t;
    assign standalone_mode = st_reg.alone;
    assign use_recovered_clock = st_reg.alone;
    assign serial_lines_idle_req = st_reg.cp_par;
    assign parallel_status = st_reg.flags;
    assign frame_sync_out = st_reg.flags[0];
    assign source_flow_out = st_reg.flags[1];
    assign control_flow_out = st_reg.flags[2];
    // held high through reset and capture so the host keeps strobes idle
    assign int_n = st_reg.alert_n;

    assign zero_power = st_reg.pwr;
    // outside stand-alone the status pin always asks for power
    assign power_status = st_reg.pwr;

    // receiver kept on while awake; in zero-power only for a short sample
    assign wake_up = st_reg.wake;
endmodule

/* File: tb/pms_props.sv */
`timescale 1ns/1ps
module pms_props (
    input wire logic clock, // core clock
    input wire logic rst_b, // sync reset
    input wire logic rx_pin, // receive line
    input wire logic frame_sync, // flag in
    input wire logic core_ready, // ready in
    input wire logic source_parallel_mode, // mode out
    input wire logic control_parallel_mode, // mode out
    input wire logic standalone_mode, // mode out
    input wire logic use_recovered_clock, // clock select
    input wire logic [2:0] parallel_status, // flag bits
    input wire logic frame_sync_out, // flag pin
    input wire logic int_n, // ready out
    input wire logic power_status, // power request
    input wire logic zero_power, // power state
    input wire logic wake_up // receiver power
);
    logic [3:0] age_reg;
    // saturating age since release keeps the capture window visible
    always_ff @(posedge clock)
        age_reg <= !rst_b ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence fsync_up;
        source_parallel_mode && $rose(frame_sync) ##1 frame_sync [*2];
    endsequence
    AST_CP_NEEDS_SRC: assert property (control_parallel_mode |-> source_parallel_mode)
        else $error("control parallel without source parallel");
    AST_MODES_HOLD: assert property (age_reg == 4'hf |->
        $stable({source_parallel_mode, control_parallel_mode, standalone_mode}))
        else $error("modes changed after capture");
    AST_READY_WAIT: assert property (age_reg < 4'ha |-> int_n)
        else $error("ready shown before capture");
    AST_READY_RESP: assert property (age_reg == 4'hf && core_ready |-> ##1 !int_n)
        else $error("ready not shown");
    AST_FLAG_LAT: assert property (fsync_up |-> ##1 parallel_status[0] && frame_sync_out)
        else $error("frame sync not shown");
    AST_FLAG_SERIAL: assert property (!source_parallel_mode |-> parallel_status == 3'h0)
        else $error("flags shown in serial mode");
    AST_CLK_SEL: assert property (use_recovered_clock == standalone_mode)
        else $error("clock select wrong");
    AST_WAKE_ACT: assert property (standalone_mode && rx_pin != $past(rx_pin) |->
        ##[1:4] !power_status)
        else $error("activity did not leave zero-power");
    AST_PWR_MIRROR: assert property (zero_power == power_status && (zero_power || wake_up))
        else $error("power outputs disagree");
    AST_NO_ZP: assert property (!standalone_mode |-> !power_status)
        else $error("zero-power outside stand-alone");
endmodule
bind pms_top pms_props pms_props_inst (.*);

/* File: tb/pms_host.sv */
`timescale 1ns/1ps
module pms_host (
    input wire logic clock, // core clock
    input wire logic int_n, // ready from block
    input wire logic [4:0] cfg, // scl, src, cp, timing, stand-alone
    output logic scl_pin, // strap
    output logic parallel_source_select, // strap
    output logic parallel_control_select, // strap
    output logic handshake_timing_select, // strap
    output logic rd_n, // strobe
    output logic wr_n // strobe
);
    always @(negedge clock)
    begin
        scl_pin <= cfg[4];
        parallel_source_select <= cfg[3];
        parallel_control_select <= cfg[2];
        handshake_timing_select <= cfg[1];
        // stand-alone holds both strobes low; otherwise they follow int_n: high until ready, then low
        rd_n <= !cfg[0] && int_n;
        wr_n <= !cfg[0] && int_n;
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic clock = 0, rst_b = 0, rx_pin = 0, core_ready = 0;
    logic [4:0] cfg = 5'h10;
    logic [2:0] flags = 3'h0;
    logic [4:0] wake_n;
    logic scl_pin, parallel_source_select, parallel_control_select, handshake_timing_select;
    logic rd_n, wr_n, frame_sync, source_flow_flag, control_flow_flag;
    logic serial_i2c_mode, source_parallel_mode, control_parallel_mode, handshake_timing_select_handshake_mode;
    logic standalone_mode, use_recovered_clock, serial_lines_idle_req, int_n;
    logic frame_sync_out, source_flow_out, control_flow_out, power_status, zero_power, wake_up;
    logic [2:0] parallel_status;
    int n_compared = 0, miscompares = 0;
    assign {control_flow_flag, source_flow_flag, frame_sync} = flags;
    pms_host pms_host_inst (.clock(clock), .int_n(int_n), .cfg(cfg), .scl_pin(scl_pin),
        .parallel_source_select(parallel_source_select),
        .parallel_control_select(parallel_control_select),
        .handshake_timing_select(handshake_timing_select), .rd_n(rd_n), .wr_n(wr_n));
    pms_top #(.IDLE_CYCLES(20), .WAKE_PERIOD_CYCLES(16), .WAKE_ON_CYCLES(4)) pms_top_inst (.*);
    initial forever #4 clock = ~clock;
    task automatic boot(input logic [4:0] c);
        @(negedge clock);
        rst_b = 0;
        cfg = c;
        flags = 3'h0;
        core_ready = 0;
        repeat (12) @(negedge clock);
        rst_b = 1;
        repeat (16) @(negedge clock);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    logic [4:0] cfgs [4] = '{5'h10, 5'h0e, 5'h14, 5'h01};
    logic [5:0] exps [4] = '{6'h20, 6'h1d, 6'h20, 6'h02};
    logic [4:0] fcfg [2] = '{5'h0e, 5'h18};
    logic [5:0] fexp [2] = '{6'h3f, 6'h1b};
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            boot(cfgs[i]);
            `CHK("int_n before ready", 1'b1, int_n)
            core_ready = 1;
            repeat (2) @(negedge clock);
            `CHK("int_n ready", 1'b0, int_n)
            repeat (3) @(negedge clock);
            `CHK("modes", exps[i], {serial_i2c_mode, source_parallel_mode, control_parallel_mode,
                handshake_timing_select_handshake_mode, standalone_mode, serial_lines_idle_req})
            $display("strap case %0d done", i);
        end
        for (int i = 0; i < 2; i++)
        begin
            boot(fcfg[i]);
            flags = 3'h7;
            repeat (4) @(negedge clock);
            `CHK("flags", fexp[i], {parallel_status, control_flow_out, source_flow_out,
                frame_sync_out})
            $display("flag case %0d done", i);
        end
        boot(5'h01);
        `CHK("power idle", 1'b1, power_status)
        wake_n = 5'h0;
        repeat (16)
        begin
            @(negedge clock);
            wake_n += {4'h0, wake_up};
        end
        `CHK("wake on-cycles", 5'h04, wake_n)
        rx_pin = 1;
        repeat (6) @(negedge clock);
        `CHK("power active", 1'b0, power_status)
        repeat (30) @(negedge clock);
        `CHK("power silent", 1'b1, power_status)
        $display("power case done");
        tally_and_finish();
    end
endmodule
